// ===== hdl/acl_map.svh
// Summary of operation
// - Map mode 00 forwards with the look-up table map only.
// - Map mode 01 forwards with entry map OR look-up table map.
// - Map mode 10 forwards with entry map AND look-up table map.
// - Map mode 11 lets the entry map replace the look-up table map.
// - Map bits 0,1,2,4 are ports 1,2,3,4; bit 3 is unused.
// - With match mode 01 and enable class 00, map bit 4 picks us or ms.
// - Counter use, map bit 3 clear: load action value, count down, interrupt at expiry.
// - Counter use, map bit 3 set: count matched packets, interrupt at action value.
// - Sixteen rule-set bits mark entries belonging to the port's cascade set.
// - Rule-set bits 15..8 at offset 0x0C, 7..0 at 0x0D, read/write, reset zero.
// - Each of fourteen byte-select bits includes or excludes one entry byte.
// - Byte-select bit 0 governs entry byte 0x0D, bit 13 governs byte 0x00.
// - Byte-select 13..8 sit low at 0x10 with top bits zero, 7..0 at 0x11.
// - Four-bit entry index in control picks which of sixteen entries is accessed.
// - Write and read status read 0 while busy, 1 when done, reset 1.
`ifndef ACL_MAP_SVH
`define ACL_MAP_SVH
`define ADDR_SELECT      8'h6E
`define ADDR_OFFSET      8'h6F
`define ADDR_DATA        8'hA0
`define CLASS_ACL        3'h2
`define ENTRY_BYTES      14
`define ENTRY_COUNT      16
`define ENTRY_BITS       112
`define OFS_MODE_BYTE    4'h1
`define OFS_ACTION_HI    4'hA
`define OFS_ACTION_LO    4'hB
`define OFS_ENTRY_CASCADE_SET_HI   4'hC
`define OFS_ENTRY_CASCADE_SET_LO   4'hD
`define OFS_STAGE_END    8'h0E
`define OFS_BSEL_HI      8'h10
`define OFS_BSEL_LO      8'h11
`define OFS_CONTROL      8'h12
`define CTRL_WR_STAT     6
`define CTRL_RD_STAT     5
`define CTRL_WR_REQ      4
`define MAP_LUT_ONLY     2'h0
`define MAP_OR           2'h1
`define MAP_AND          2'h2
`define MAP_REPLACE      2'h3
`define MATCH_MODE_CNT   2'h1
`define ENABLE_CLASS_CNT 2'h0
`define FWD_UNUSED_BIT   3
`define FWD_UNIT_BIT     4
`define FWD_KEEP_MASK    5'h17
`define CLK_PERIOD_NS    8
`define US_NS            1000
`define MS_NS            1000000
`define US_CYCLES        (`US_NS / `CLK_PERIOD_NS)
`define MS_CYCLES        (`MS_NS / `CLK_PERIOD_NS)
`endif

// ===== hdl/acl_pkg.sv
package acl_pkg;
`include "acl_map.svh"
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_WRITE = 4'h2,
        ST_FETCH = 4'h4,
        ST_READ  = 4'h8
    } op_state_type;

    typedef struct packed {
        op_state_type                        st;
        logic [7:0]                          sel;
        logic [7:0]                          ofs;
        logic [`ENTRY_BYTES-1:0][7:0]        stage;
        logic [`ENTRY_BYTES-1:0]             bsel;
        logic                                wr_req;
        logic [3:0]                          idx;
        logic                                wr_done;
        logic                                rd_done;
        logic [7:0]                          rdata;
        logic                                m_pend;
        logic [4:0]                          lut;
        logic [4:0]                          fwd;
        logic                                fwd_vld;
        logic [15:0]                         cascade;
        logic                                cnt_run;
        logic                                cnt_up;
        logic                                cnt_ms;
        logic [10:0]                         cnt;
        logic [10:0]                         target;
        logic [31:0]                         pre;
        logic                                irq;
    } acl_state_type;

    typedef struct packed {
        logic [`ENTRY_COUNT-1:0][`ENTRY_BITS-1:0] arr;
        logic [`ENTRY_BITS-1:0]                   qa;
        logic [`ENTRY_BITS-1:0]                   qb;
    } mem_state_type;
endpackage

// ===== hdl/acl_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface acl_mem_if;
    logic                    wr_en;
    logic [3:0]              wr_idx;
    logic [111:0]            wr_data;
    logic [13:0]             wr_be;
    logic [3:0]              rd_idx_a;
    logic [111:0]            rd_data_a;
    logic [3:0]              rd_idx_b;
    logic [111:0]            rd_data_b;
    modport ctrl (output wr_en, wr_idx, wr_data, wr_be, rd_idx_a, rd_idx_b, input rd_data_a, rd_data_b);
    modport mem  (input wr_en, wr_idx, wr_data, wr_be, rd_idx_a, rd_idx_b, output rd_data_a, rd_data_b);
endinterface
`default_nettype wire

// ===== hdl/acl_entry_mem.sv
`timescale 1ns/100ps
`default_nettype none
module acl_entry_mem
    import acl_pkg::*;
(
    // Clock and reset.
    input  wire logic  i_clk,
    input  wire logic  i_resetn,
    // Table port.
    acl_mem_if.mem     mbus
);
    mem_state_type s_ff;
    mem_state_type nxt_s;

    // Byte-masked write, two registered read ports.
    always_comb begin
        nxt_s = s_ff;
        if (mbus.wr_en) begin
            for (int k = 0; k < `ENTRY_BYTES; k++) begin
                if (mbus.wr_be[k]) begin
                    nxt_s.arr[mbus.wr_idx][8*k +: 8] = mbus.wr_data[8*k +: 8];
                end
            end
        end
        nxt_s.qa = s_ff.arr[mbus.rd_idx_a];
        nxt_s.qb = s_ff.arr[mbus.rd_idx_b];
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign mbus.rd_data_a = s_ff.qa;
    assign mbus.rd_data_b = s_ff.qb;
endmodule
`default_nettype wire

// ===== hdl/acl_action_and_byte_staging.sv
`timescale 1ns/100ps
`default_nettype none
module acl_action_and_byte_staging
    import acl_pkg::*;
#(
    parameter logic [3:0] PORT_ID   = 4'h1,
    parameter int         MS_CYCLES = `MS_CYCLES
) (
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // Switch register port.
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    // Match side.
    input  wire logic        i_match,
    input  wire logic [3:0]  i_match_entry,
    input  wire logic [4:0]  i_lut_map,
    output logic      [4:0]  o_fwd_map,
    output logic             o_fwd_valid,
    output logic      [15:0] o_cascade_set,
    output logic             o_irq
);
    acl_state_type s_ff;
    acl_state_type nxt_s;
    acl_mem_if     mbus ();
    logic          acc_ok;
    logic [111:0]  ent;
    logic [7:0]    act_lo;
    logic [7:0]    act_hi;
    logic [7:0]    mode_b;
    logic [1:0]    ent_mm;
    logic [4:0]    ent_fwd;
    logic [10:0]   ent_val;
    logic          cnt_use;
    logic [31:0]   unit_cyc;

    acl_entry_mem u_mem (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .mbus     (mbus.mem)
    );

    // Byte-select bit i governs entry byte 13-i.
    function automatic logic [13:0] byte_enables(input logic [13:0] bsel);
        logic [13:0] be;
        for (int k = 0; k < `ENTRY_BYTES; k++) begin
            be[k] = bsel[`ENTRY_BYTES-1-k];
        end
        return be;
    endfunction

    function automatic logic [7:0] entry_byte(input logic [111:0] e, input logic [3:0] b);
        return e[8*b +: 8];
    endfunction

    //----------------------------------------------------------------
    // Table port and matched entry fields.
    //----------------------------------------------------------------
    assign mbus.wr_en    = (s_ff.st == ST_WRITE);
    assign mbus.wr_idx   = s_ff.idx;
    assign mbus.wr_data  = s_ff.stage;
    assign mbus.wr_be    = byte_enables(s_ff.bsel);
    assign mbus.rd_idx_a = s_ff.idx;
    assign mbus.rd_idx_b = i_match_entry;

    assign ent      = mbus.rd_data_b;
    assign act_lo   = entry_byte(ent, `OFS_ACTION_LO);
    assign act_hi   = entry_byte(ent, `OFS_ACTION_HI);
    assign mode_b   = entry_byte(ent, `OFS_MODE_BYTE);
    assign ent_mm   = act_lo[6:5];
    assign ent_fwd  = act_lo[4:0];
    assign ent_val  = {act_hi, act_lo[7:5]};
    assign cnt_use  = (mode_b[5:4] == `MATCH_MODE_CNT) &&
                      (mode_b[3:2] == `ENABLE_CLASS_CNT);
    assign unit_cyc = s_ff.cnt_ms ? 32'(MS_CYCLES) : 32'(`US_CYCLES);
    assign acc_ok   = (s_ff.sel[7:5] == `CLASS_ACL) && (s_ff.sel[3:0] == PORT_ID);

    //----------------------------------------------------------------
    // Next state.
    //----------------------------------------------------------------
    always_comb begin
        nxt_s         = s_ff;
        nxt_s.fwd_vld = 1'b0;
        nxt_s.irq     = 1'b0;
        // Host writes.
        if (i_reg_wr) begin
            case (i_reg_addr)
                `ADDR_SELECT: begin
                    nxt_s.sel = i_reg_wdata;
                end
                `ADDR_OFFSET: begin
                    nxt_s.ofs = i_reg_wdata;
                end
                `ADDR_DATA: begin
                    if (acc_ok) begin
                        if (s_ff.ofs < `OFS_STAGE_END) begin
                            nxt_s.stage[s_ff.ofs[3:0]] = i_reg_wdata;
                        end else if (s_ff.ofs == `OFS_BSEL_HI) begin
                            nxt_s.bsel[13:8] = i_reg_wdata[5:0];
                        end else if (s_ff.ofs == `OFS_BSEL_LO) begin
                            nxt_s.bsel[7:0] = i_reg_wdata;
                        end else if (s_ff.ofs == `OFS_CONTROL && s_ff.st == ST_IDLE) begin
                            nxt_s.wr_req = i_reg_wdata[`CTRL_WR_REQ];
                            nxt_s.idx    = i_reg_wdata[3:0];
                            if (i_reg_wdata[`CTRL_WR_REQ]) begin
                                nxt_s.st      = ST_WRITE;
                                nxt_s.wr_done = 1'b0;
                            end else begin
                                nxt_s.st      = ST_FETCH;
                                nxt_s.rd_done = 1'b0;
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // Host reads; unmapped or deselected reads return zero.
        if (i_reg_rd) begin
            case (i_reg_addr)
                `ADDR_SELECT: nxt_s.rdata = s_ff.sel;
                `ADDR_OFFSET: nxt_s.rdata = s_ff.ofs;
                `ADDR_DATA: begin
                    nxt_s.rdata = 8'h00;
                    if (acc_ok) begin
                        if (s_ff.ofs < `OFS_STAGE_END) begin
                            nxt_s.rdata = s_ff.stage[s_ff.ofs[3:0]];
                        end else if (s_ff.ofs == `OFS_BSEL_HI) begin
                            nxt_s.rdata = {2'h0, s_ff.bsel[13:8]};
                        end else if (s_ff.ofs == `OFS_BSEL_LO) begin
                            nxt_s.rdata = s_ff.bsel[7:0];
                        end else if (s_ff.ofs == `OFS_CONTROL) begin
                            nxt_s.rdata = {1'b0, s_ff.wr_done, s_ff.rd_done, s_ff.wr_req, s_ff.idx};
                        end
                    end
                end
                default: nxt_s.rdata = 8'h00;
            endcase
        end
        // Table operation sequencer.
        case (s_ff.st)
            ST_IDLE: begin
            end
            ST_WRITE: begin
                nxt_s.st      = ST_IDLE;
                nxt_s.wr_done = 1'b1;
            end
            ST_FETCH: begin
                nxt_s.st = ST_READ;
            end
            ST_READ: begin
                for (int k = 0; k < `ENTRY_BYTES; k++) begin
                    if (mbus.wr_be[k]) begin
                        nxt_s.stage[k] = mbus.rd_data_a[8*k +: 8];
                    end
                end
                nxt_s.st      = ST_IDLE;
                nxt_s.rd_done = 1'b1;
            end
            default: begin
                nxt_s.st = ST_IDLE;
            end
        endcase
        // Count-down timer tick.
        if (s_ff.cnt_run && !s_ff.cnt_up) begin
            if (s_ff.pre >= unit_cyc - 32'h1) begin
                nxt_s.pre = 32'h0;
                nxt_s.cnt = s_ff.cnt - 11'h1;
                if (s_ff.cnt <= 11'h1) begin
                    nxt_s.cnt_run = 1'b0;
                    nxt_s.irq     = 1'b1;
                end
            end else begin
                nxt_s.pre = s_ff.pre + 32'h1;
            end
        end
        // Match pipeline: entry data arrives one cycle after the match.
        nxt_s.m_pend = i_match;
        nxt_s.lut    = i_lut_map;
        if (s_ff.m_pend) begin
            nxt_s.fwd_vld = 1'b1;
            nxt_s.cascade = {entry_byte(ent, `OFS_ENTRY_CASCADE_SET_HI), entry_byte(ent, `OFS_ENTRY_CASCADE_SET_LO)};
            case (ent_mm)
                `MAP_LUT_ONLY: nxt_s.fwd = s_ff.lut;
                `MAP_OR:       nxt_s.fwd = s_ff.lut | ent_fwd;
                `MAP_AND:      nxt_s.fwd = s_ff.lut & ent_fwd;
                default:       nxt_s.fwd = ent_fwd;
            endcase
            nxt_s.fwd = nxt_s.fwd & `FWD_KEEP_MASK;
            if (cnt_use) begin
                if (ent_fwd[`FWD_UNUSED_BIT]) begin
                    nxt_s.cnt_up = 1'b1;
                    nxt_s.target = ent_val;
                    nxt_s.cnt    = (s_ff.cnt_run && s_ff.cnt_up) ? s_ff.cnt + 11'h1 : 11'h1;
                    nxt_s.cnt_run = 1'b1;
                    if (nxt_s.cnt >= ent_val) begin
                        nxt_s.cnt_run = 1'b0;
                        nxt_s.irq     = 1'b1;
                    end
                end else begin
                    nxt_s.cnt_up  = 1'b0;
                    nxt_s.cnt_ms  = ent_fwd[`FWD_UNIT_BIT];
                    nxt_s.cnt     = ent_val;
                    nxt_s.pre     = 32'h0;
                    nxt_s.cnt_run = (ent_val != 11'h0);
                    nxt_s.irq     = nxt_s.irq | (ent_val == 11'h0);
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_ff         <= '0;
            s_ff.st      <= ST_IDLE;
            s_ff.wr_done <= 1'b1;
            s_ff.rd_done <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign o_reg_rdata   = s_ff.rdata;
    assign o_fwd_map     = s_ff.fwd;
    assign o_fwd_valid   = s_ff.fwd_vld;
    assign o_cascade_set = s_ff.cascade;
    assign o_irq         = s_ff.irq;

    //----------------------------------------------------------------
    // Checks.
    //----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence ctrl_wr_s(logic rq);
        i_reg_wr && i_reg_addr == `ADDR_DATA && acc_ok && s_ff.ofs == `OFS_CONTROL &&
            s_ff.st == ST_IDLE && i_reg_wdata[`CTRL_WR_REQ] == rq;
    endsequence

    map_lut_a:   assert property (s_ff.m_pend && ent_mm == `MAP_LUT_ONLY |=>
        o_fwd_valid && o_fwd_map == ($past(s_ff.lut) & `FWD_KEEP_MASK)) else $error("lut only map wrong");
    map_or_a:    assert property (s_ff.m_pend && ent_mm == `MAP_OR |=>
        o_fwd_map == (($past(s_ff.lut) | $past(ent_fwd)) & `FWD_KEEP_MASK)) else $error("or map wrong");
    map_and_a:   assert property (s_ff.m_pend && ent_mm == `MAP_AND |=>
        o_fwd_map == (($past(s_ff.lut) & $past(ent_fwd)) & `FWD_KEEP_MASK)) else $error("and map wrong");
    map_repl_a:  assert property (s_ff.m_pend && ent_mm == `MAP_REPLACE |=>
        o_fwd_map == ($past(ent_fwd) & `FWD_KEEP_MASK)) else $error("replace map wrong");
    unused_bit_a: assert property (o_fwd_valid |-> !o_fwd_map[`FWD_UNUSED_BIT]) else $error("bit 3 set");
    write_busy_a: assert property (ctrl_wr_s(1'b1) |=> !s_ff.wr_done ##1 s_ff.wr_done)
        else $error("write status sequence wrong");
    read_busy_a: assert property (ctrl_wr_s(1'b0) |=> !s_ff.rd_done [*2] ##1 s_ff.rd_done)
        else $error("read status sequence wrong");
    bsel_top_a:  assert property (i_reg_rd && i_reg_addr == `ADDR_DATA && s_ff.ofs == `OFS_BSEL_HI |=>
        o_reg_rdata[7:6] == 2'h0) else $error("byte select top bits not zero");
    count_up_a:  assert property (s_ff.m_pend && cnt_use && ent_fwd[`FWD_UNUSED_BIT] &&
        s_ff.cnt_run && s_ff.cnt_up && s_ff.cnt + 11'h1 == ent_val |=> o_irq && !s_ff.cnt_run)
        else $error("count up interrupt missing");
    count_dn_a:  assert property (s_ff.cnt_run && !s_ff.cnt_up && s_ff.cnt == 11'h1 &&
        s_ff.pre == unit_cyc - 32'h1 && !s_ff.m_pend |=> o_irq) else $error("expiry interrupt missing");
endmodule
`default_nettype wire

// ===== test/acl_action_and_byte_staging_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module acl_action_and_byte_staging_tb_top;
    import acl_pkg::*;

    //------------------------------------------------------------
    // Signals
    //------------------------------------------------------------
    logic        clk;
    logic        resetn;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        match;
    logic [3:0]  match_entry;
    logic [4:0]  lut_map;
    logic [4:0]  fwd_map;
    logic        fwd_valid;
    logic [15:0] cascade_set;
    logic        irq;
    int          error_cnt   = 0;
    int          checks_done = 0;
    int          cyc         = 0;
    int          irq_cnt     = 0;

    acl_action_and_byte_staging #(.PORT_ID(4'h1), .MS_CYCLES(20)) u_acl_action_and_byte_staging (
        .i_clk(clk), .i_resetn(resetn), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .i_match(match), .i_match_entry(match_entry),
        .i_lut_map(lut_map), .o_fwd_map(fwd_map), .o_fwd_valid(fwd_valid), .o_cascade_set(cascade_set),
        .o_irq(irq));

    //------------------------------------------------------------
    // Clock, timeout and interrupt counting
    //------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    //------------------------------------------------------------
    // Shared tasks
    //------------------------------------------------------------
    task automatic close_out();
        $display("Counts: %0d checks, %0d mismatches", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
            error_cnt++;
        end
    endtask

    task automatic reg_wr_t(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        // One idle edge keeps back-to-back strobes apart.
        @(negedge clk);
    endtask

    task automatic reg_rd_t(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a; reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
        @(negedge clk);
    endtask

    // Select ACL class on port 1, set the offset, then move one byte.
    task automatic ind_wr(input logic [7:0] ofs, input logic [7:0] d);
        reg_wr_t(8'h6E, 8'h41);
        reg_wr_t(8'h6F, ofs);
        reg_wr_t(8'hA0, d);
    endtask

    task automatic ind_rd(input logic [7:0] ofs, output logic [7:0] d);
        reg_wr_t(8'h6E, 8'h41);
        reg_wr_t(8'h6F, ofs);
        reg_rd_t(8'hA0, d);
    endtask

    task automatic wait_done(input int bitpos);
        logic [7:0] v;
        for (int n = 0; n < 20; n++) begin
            ind_rd(8'h12, v);
            if (v[bitpos] === 1'b1) break;
        end
        check(v[bitpos], 1'b1);
    endtask

    task automatic load_entry(input logic [3:0] idx, input logic [7:0] b1, input logic [7:0] ba,
                              input logic [7:0] bb, input logic [15:0] rs);
        ind_wr(8'h10, 8'h3F);
        ind_wr(8'h11, 8'hFF);
        ind_wr(8'h01, b1);
        ind_wr(8'h0A, ba);
        ind_wr(8'h0B, bb);
        ind_wr(8'h0C, rs[15:8]);
        ind_wr(8'h0D, rs[7:0]);
        ind_wr(8'h12, {4'h1, idx});
        wait_done(6);
    endtask

    task automatic send_match(input logic [3:0] e, input logic [4:0] l);
        match = 1'b1; match_entry = e; lut_map = l;
        @(negedge clk);
        match = 1'b0;
    endtask

    //------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------
    task automatic test_reset();
        logic [7:0] v;
        ind_rd(8'h0C, v); check(v, 8'h00);
        ind_rd(8'h0D, v); check(v, 8'h00);
        ind_rd(8'h10, v); check(v, 8'h00);
        ind_rd(8'h11, v); check(v, 8'h00);
        ind_rd(8'h12, v); check(v, 8'h60);
        $display("test_reset done");
    endtask

    task automatic test_regs();
        logic [7:0] v;
        ind_wr(8'h0C, 8'hA5); ind_wr(8'h0D, 8'h5A);
        ind_wr(8'h10, 8'hFF); ind_wr(8'h11, 8'hC3);
        ind_rd(8'h0C, v); check(v, 8'hA5);
        ind_rd(8'h0D, v); check(v, 8'h5A);
        ind_rd(8'h10, v); check(v, 8'h3F);
        ind_rd(8'h11, v); check(v, 8'hC3);
        ind_rd(8'h0E, v); check(v, 8'h00);
        reg_wr_t(8'h6E, 8'h42);
        reg_rd_t(8'hA0, v); check(v, 8'h00);
        reg_rd_t(8'h55, v); check(v, 8'h00);
        $display("test_regs done");
    endtask

    // Write entry 5 with all bytes, then read back only bytes 0x00 and 0x0D.
    task automatic test_table();
        logic [7:0] v;
        ind_wr(8'h10, 8'h3F); ind_wr(8'h11, 8'hFF);
        for (int k = 0; k < 14; k++) ind_wr(8'(k), 8'(8'h10 + k));
        ind_wr(8'h12, 8'h15);
        wait_done(6);
        for (int k = 0; k < 14; k++) ind_wr(8'(k), 8'h00);
        ind_wr(8'h10, 8'h20); ind_wr(8'h11, 8'h01);
        ind_wr(8'h12, 8'h05);
        reg_rd_t(8'hA0, v); check(v[5], 1'b0);
        wait_done(5);
        ind_rd(8'h12, v); check(v, 8'h65);
        ind_rd(8'h00, v); check(v, 8'h10);
        ind_rd(8'h0D, v); check(v, 8'h1D);
        ind_rd(8'h01, v); check(v, 8'h00);
        ind_rd(8'h0C, v); check(v, 8'h00);
        ind_wr(8'h10, 8'h3F); ind_wr(8'h11, 8'hFF);
        ind_wr(8'h12, 8'h00);
        wait_done(5);
        ind_rd(8'h00, v); check(v, 8'h00);
        $display("test_table done");
    endtask

    // Each map mode in its own entry; entry map includes the unused bit.
    task automatic test_map_modes();
        logic [4:0] e;
        logic [4:0] l;
        logic [4:0] exp[4];
        int         seen;
        e = 5'b11011;
        l = 5'b10101;
        exp[0] = l & 5'h17;
        exp[1] = (e | l) & 5'h17;
        exp[2] = (e & l) & 5'h17;
        exp[3] = e & 5'h17;
        for (int m = 0; m < 4; m++) load_entry(4'(m), 8'h00, 8'h00, {1'b0, 2'(m), e}, {8'(m), 8'h81});
        for (int m = 0; m < 4; m++) begin
            send_match(4'(m), l);
            seen = 0;
            for (int n = 0; n < 4 && seen == 0; n++) begin
                if (fwd_valid === 1'b1) seen = 1;
                else @(negedge clk);
            end
            check(seen, 1);
            check(fwd_map, exp[m]);
            check(cascade_set, {8'(m), 8'h81});
            @(negedge clk);
            check(fwd_valid, 1'b0);
        end
        $display("test_map_modes done");
    endtask

    // Count up to three matched packets in entry 7.
    task automatic test_count_up();
        int base;
        load_entry(4'h7, 8'h10, 8'h00, 8'h68, 16'h0000);
        base = irq_cnt;
        for (int p = 1; p <= 3; p++) begin
            send_match(4'h7, 5'h00);
            repeat (4) @(negedge clk);
            check(irq_cnt - base, (p == 3) ? 1 : 0);
        end
        $display("test_count_up done");
    endtask

    // Count down two milliseconds of twenty cycles each in entry 8, then one microsecond in entry 9.
    task automatic test_count_down();
        int base;
        load_entry(4'h8, 8'h10, 8'h00, 8'h50, 16'h0000);
        base = irq_cnt;
        send_match(4'h8, 5'h00);
        repeat (30) @(negedge clk);
        check(irq_cnt - base, 0);
        repeat (30) @(negedge clk);
        check(irq_cnt - base, 1);
        load_entry(4'h9, 8'h10, 8'h00, 8'h20, 16'h0000);
        base = irq_cnt;
        send_match(4'h9, 5'h00);
        repeat (120) @(negedge clk);
        check(irq_cnt - base, 0);
        repeat (10) @(negedge clk);
        check(irq_cnt - base, 1);
        $display("test_count_down done");
    endtask

    //------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------
    initial begin
        resetn = 1'b0; reg_addr = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0; reg_wdata = 8'h00;
        match = 1'b0; match_entry = 4'h0; lut_map = 5'h00;
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        test_reset();
        test_regs();
        test_table();
        test_map_modes();
        test_count_up();
        test_count_down();
        close_out();
    end
endmodule
`default_nettype wire
